// ---- src/utcc_top.sv ----
// upper 8-bit timer/counter with ahb-lite register slave
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module utcc_top
   import utcc_pkg::*;
(
   input wire logic hclk, // bus and fast clock fc
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready in
   output logic hreadyout, // slave ready out
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire logic fs_clk_in, // low-frequency clock pin
   input wire logic counter_pin_in, // external event pin
   input wire logic [2:0] lower_clock_select, // lower counter clock field
   input wire logic [2:0] lower_mode_select, // lower counter mode field
   input wire logic lower_overflow, // lower counter overflow pulse
   output logic lower_source_tick, // selected pair source tick
   output logic timer_out, // timer output pin
   output logic irq // level interrupt
);

   function automatic logic utcc_pick(input logic [7:0] tv, input logic [2:0] ck);
      utcc_pick = tv[ck];
   endfunction

   logic [7:0] ctrl_reg;
   logic [7:0] period_reg;
   logic [7:0] pwidth_reg;
   logic [2:0] cfg_reg;
   logic [UTCC_ST_W-1:0] status_reg;
   logic [UTCC_ST_W-1:0] status_next;
   logic [UTCC_ST_W-1:0] enable_reg;
   logic [7:0] cnt_reg;
   logic [7:0] pw_buf_reg;
   logic ff_reg;
   logic wr_pend_reg;
   logic [31:0] wa_reg;
   logic [31:0] rd_mux;
   logic [UTCC_PRE_W-1:0] pre_reg;
   logic [UTCC_FS_DIV_W-1:0] fs_div_reg;
   logic [2:0] fs_sync_reg;
   logic [2:0] pin_sync_reg;
   logic fs_lvl_reg;
   logic pin_lvl_reg;
   logic fs_tick;
   logic pin_tick;
   logic fs8_tick;
   logic [7:0] tv;

   logic run;
   logic [2:0] ck;
   logic [2:0] mode;
   logic idle;
   logic tick;
   logic step;
   logic is_pwm;
   logic is_pulse;
   logic match_ev;
   logic ovf_ev;
   logic [UTCC_ST_W-1:0] clr_bits;
   logic addr_ok;

   assign run = ctrl_reg[UTCC_RUN_BIT];
   assign ck = ctrl_reg[UTCC_CK_HI:UTCC_CK_LO];
   assign mode = ctrl_reg[UTCC_MODE_HI:UTCC_MODE_LO];

   // ---------------- ahb-lite slave ----------------
   // zero wait states; only whole-word transfers are honoured
   assign addr_ok = hsel && htrans[1] && hready && (hsize == 3'h2);

   always_comb begin
      rd_mux = 32'h0;
      unique case (haddr)
         UTCC_CTRL_ADDR: rd_mux = {24'h0, ctrl_reg};
         UTCC_PERIOD_ADDR: rd_mux = {24'h0, period_reg};
         UTCC_PWIDTH_ADDR: rd_mux = {24'h0, pwidth_reg};
         UTCC_CFG_ADDR: rd_mux = {29'h0, cfg_reg};
         UTCC_STATUS_ADDR: rd_mux = {30'h0, status_reg};
         UTCC_ENABLE_ADDR: rd_mux = {30'h0, enable_reg};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wa_reg <= 32'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_reg <= addr_ok && hwrite;
         if (addr_ok) begin
            wa_reg <= haddr;
         end
         hrdata <= (addr_ok && !hwrite) ? rd_mux : 32'h0;
      end
   end

   // register file; the whole control byte is taken on every write so
   // a start write can carry new mode, clock and ff values
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= UTCC_CTRL_RST;
         period_reg <= UTCC_PERIOD_RST;
         pwidth_reg <= UTCC_PWIDTH_RST;
         cfg_reg <= UTCC_CFG_RST;
         enable_reg <= '0;
      end else if (wr_pend_reg) begin
         unique case (wa_reg)
            UTCC_CTRL_ADDR: ctrl_reg <= hwdata[7:0];
            UTCC_PERIOD_ADDR: period_reg <= hwdata[7:0];
            UTCC_PWIDTH_ADDR: pwidth_reg <= hwdata[7:0];
            UTCC_CFG_ADDR: cfg_reg <= hwdata[2:0];
            UTCC_ENABLE_ADDR: enable_reg <= hwdata[UTCC_ST_W-1:0];
            default: ;
         endcase
      end
   end

   // ---------------- clock sources ----------------
   // pins pass three flops; a level counts once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fs_sync_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
         fs_lvl_reg <= 1'b0;
         pin_lvl_reg <= 1'b0;
      end else begin
         fs_sync_reg <= {fs_sync_reg[1:0], fs_clk_in};
         pin_sync_reg <= {pin_sync_reg[1:0], counter_pin_in};
         if (fs_sync_reg[1] == fs_sync_reg[2]) begin
            fs_lvl_reg <= fs_sync_reg[2];
         end
         if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            pin_lvl_reg <= pin_sync_reg[2];
         end
      end
   end

   assign fs_tick = (fs_sync_reg[1] == fs_sync_reg[2]) && fs_sync_reg[2] && !fs_lvl_reg;
   assign pin_tick = (pin_sync_reg[1] == pin_sync_reg[2]) && pin_sync_reg[2] && !pin_lvl_reg;
   assign fs8_tick = fs_tick && (&fs_div_reg);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_reg <= '0;
         fs_div_reg <= '0;
      end else begin
         pre_reg <= pre_reg + 1'b1;
         if (fs_tick) begin
            fs_div_reg <= fs_div_reg + 1'b1;
         end
      end
   end

   // fc taps vanish in low-clock operation; fc itself stays for warm-up use
   always_comb begin
      tv[UTCC_CK_SLOWEST] = (cfg_reg[UTCC_CFG_DIV_BIT] || cfg_reg[UTCC_CFG_SLOW_BIT]) ? fs8_tick
                            : (&pre_reg);
      tv[UTCC_CK_FC_DIV7] = (&pre_reg[6:0]) && !cfg_reg[UTCC_CFG_SLOW_BIT];
      tv[UTCC_CK_FC_DIV5] = (&pre_reg[4:0]) && !cfg_reg[UTCC_CFG_SLOW_BIT];
      tv[UTCC_CK_FC_DIV3] = (&pre_reg[2:0]) && !cfg_reg[UTCC_CFG_SLOW_BIT];
      tv[UTCC_CK_FS] = fs_tick;
      tv[UTCC_CK_FC_DIV1] = pre_reg[0] && !cfg_reg[UTCC_CFG_SLOW_BIT];
      tv[UTCC_CK_FC] = 1'b1;
      tv[UTCC_CK_PIN] = pin_tick;
   end

   // the pair's source tick is chosen by the lower clock field
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lower_source_tick <= 1'b0;
      end else begin
         lower_source_tick <= utcc_pick(tv, lower_clock_select);
      end
   end

   // ---------------- counter core ----------------
   // sixteen-bit modes need the lower counter parked in cascade mode
   assign idle = (mode == UTCC_M_RSVD)
                 || (mode[2] && (lower_mode_select != UTCC_LOWER_CASCADE));
   assign tick = mode[2] ? lower_overflow : utcc_pick(tv, ck);
   assign step = run && tick && !idle;
   assign is_pwm = (mode == UTCC_M_PWM8) || (mode == UTCC_M_PWM16);
   assign is_pulse = (mode == UTCC_M_DIV8) || is_pwm || (mode == UTCC_M_PULSE16);
   assign match_ev = step && !is_pwm && (cnt_reg == period_reg);
   assign ovf_ev = step && is_pwm && (cnt_reg == UTCC_CNT_TOP);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= 8'h0;
         ff_reg <= 1'b0;
         pw_buf_reg <= UTCC_PWIDTH_RST;
      end else if (!run) begin
         cnt_reg <= 8'h0;
         ff_reg <= ctrl_reg[UTCC_FF_BIT];
         pw_buf_reg <= pwidth_reg;
      end else if (step) begin
         unique case (mode)
            UTCC_M_TIMER8, UTCC_M_TIMER16, UTCC_M_WARMUP: begin
               cnt_reg <= match_ev ? 8'h0 : cnt_reg + 8'h1;
            end
            UTCC_M_DIV8: begin
               cnt_reg <= match_ev ? 8'h0 : cnt_reg + 8'h1;
               if (match_ev) begin
                  ff_reg <= ~ff_reg;
               end
            end
            UTCC_M_PWM8, UTCC_M_PWM16: begin
               // width is double-buffered so it may change while running
               cnt_reg <= cnt_reg + 8'h1;
               if (cnt_reg == pw_buf_reg) begin
                  ff_reg <= ~ff_reg;
               end
               if (ovf_ev) begin
                  ff_reg <= ctrl_reg[UTCC_FF_BIT];
                  pw_buf_reg <= pwidth_reg;
               end
            end
            UTCC_M_PULSE16: begin
               cnt_reg <= match_ev ? 8'h0 : cnt_reg + 8'h1;
               if (cnt_reg == pwidth_reg) begin
                  ff_reg <= ~ff_reg;
               end
               if (match_ev) begin
                  ff_reg <= ctrl_reg[UTCC_FF_BIT];
               end
            end
            default: ;
         endcase
      end
   end

   // pin only carries pulses in pulse modes with output enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_out <= 1'b0;
      end else begin
         timer_out <= is_pulse && !cfg_reg[UTCC_CFG_ODIS_BIT] && ff_reg;
      end
   end

   // ---------------- interrupts ----------------
   assign clr_bits = (wr_pend_reg && (wa_reg == UTCC_CLEAR_ADDR)) ? hwdata[UTCC_ST_W-1:0] : '0;

   always_comb begin
      status_next = status_reg & ~clr_bits;
      // set wins over a clear in the same cycle
      status_next[UTCC_ST_MATCH_BIT] = status_next[UTCC_ST_MATCH_BIT] | match_ev;
      status_next[UTCC_ST_OVF_BIT] = status_next[UTCC_ST_OVF_BIT] | ovf_ev;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= '0;
         irq <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq <= |(status_reg & enable_reg);
      end
   end

   // ---------------- checks ----------------
   sequence s_ctrl_write;
      wr_pend_reg && (wa_reg == UTCC_CTRL_ADDR);
   endsequence

   sequence s_start_write;
      s_ctrl_write and (!run && hwdata[UTCC_RUN_BIT]);
   endsequence

   chk_start_takes_fields: assert property (@(posedge hclk) disable iff (!hresetn)
      s_start_write |=> (ctrl_reg == $past(hwdata[7:0])))
      else $error("start write did not load control fields");

   chk_period_store: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && (wa_reg == UTCC_PERIOD_ADDR)) |=> (period_reg == $past(hwdata[7:0])))
      else $error("period register not written");

   chk_stop_clears: assert property (@(posedge hclk) disable iff (!hresetn)
      !run |=> (cnt_reg == 8'h0))
      else $error("stopped counter not cleared");

   chk_match_irq_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
      match_ev |=> (status_reg[UTCC_ST_MATCH_BIT] && (cnt_reg == 8'h0)))
      else $error("match did not flag and clear");

   chk_timer_counts: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && (mode == UTCC_M_TIMER8) && !match_ev) |=> (cnt_reg == $past(cnt_reg) + 8'h1))
      else $error("timer did not advance on tick");

   chk_reserved_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && (mode == UTCC_M_RSVD)) [*2] |-> ($stable(cnt_reg) && !match_ev && !ovf_ev))
      else $error("reserved mode moved the counter");

   chk_cascade_clock: assert property (@(posedge hclk) disable iff (!hresetn)
      (run && mode[2] && !lower_overflow && !clr_bits[0] && !(wr_pend_reg && (wa_reg == UTCC_CTRL_ADDR)))
      |=> $stable(cnt_reg))
      else $error("upper counter moved without cascade overflow");

   chk_ff_follows: assert property (@(posedge hclk) disable iff (!hresetn)
      !run |=> (ff_reg == $past(ctrl_reg[UTCC_FF_BIT])))
      else $error("stopped ff does not follow control");

   chk_output_disable: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_reg[UTCC_CFG_ODIS_BIT] |=> !timer_out)
      else $error("output pulsed while disabled");

   chk_pair_source: assert property (@(posedge hclk) disable iff (!hresetn)
      (lower_clock_select == UTCC_CK_FC) |=> lower_source_tick)
      else $error("pair source ignores lower clock select");

   chk_fc_div3_rate: assert property (@(posedge hclk) disable iff (!hresetn)
      (!cfg_reg[UTCC_CFG_SLOW_BIT] && (pre_reg[2:0] == 3'h7)) |-> tv[UTCC_CK_FC_DIV3] ##1 !tv[UTCC_CK_FC_DIV3])
      else $error("fc/8 tap wrong");

   chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
      (|(status_reg & enable_reg)) |=> irq)
      else $error("enabled status did not raise interrupt");

endmodule

`default_nettype wire

// ---- src/utcc_pkg.sv ----
// constants and types for the upper timer/counter control block
package utcc_pkg;

   // control register index and byte address (index times four)
   localparam logic [31:0] UTCC_CTRL_IDX = 32'h0000_001b;
   localparam logic [31:0] UTCC_CTRL_ADDR = 32'h0000_006c;
   localparam logic [31:0] UTCC_PERIOD_ADDR = 32'h0000_0070;
   localparam logic [31:0] UTCC_PWIDTH_ADDR = 32'h0000_0074;
   localparam logic [31:0] UTCC_CFG_ADDR = 32'h0000_0078;
   localparam logic [31:0] UTCC_STATUS_ADDR = 32'h0000_007c;
   localparam logic [31:0] UTCC_CLEAR_ADDR = 32'h0000_0080;
   localparam logic [31:0] UTCC_ENABLE_ADDR = 32'h0000_0084;

   // control register fields
   localparam int UTCC_FF_BIT = 7;
   localparam int UTCC_CK_HI = 6;
   localparam int UTCC_CK_LO = 4;
   localparam int UTCC_RUN_BIT = 3;
   localparam int UTCC_MODE_HI = 2;
   localparam int UTCC_MODE_LO = 0;

   // configuration register fields
   localparam int UTCC_CFG_DIV_BIT = 0;
   localparam int UTCC_CFG_SLOW_BIT = 1;
   localparam int UTCC_CFG_ODIS_BIT = 2;

   // status / clear / enable fields
   localparam int UTCC_ST_MATCH_BIT = 0;
   localparam int UTCC_ST_OVF_BIT = 1;
   localparam int UTCC_ST_W = 2;

   // reset values
   localparam logic [7:0] UTCC_CTRL_RST = 8'h00;
   localparam logic [7:0] UTCC_PERIOD_RST = 8'hff;
   localparam logic [7:0] UTCC_PWIDTH_RST = 8'h00;
   localparam logic [2:0] UTCC_CFG_RST = 3'h0;

   // prescaler width on the fast clock, fs divider width, lower cascade code, counter top
   localparam int UTCC_PRE_W = 11;
   localparam int UTCC_FS_DIV_W = 3;
   localparam logic [2:0] UTCC_LOWER_CASCADE = 3'h3;
   localparam logic [7:0] UTCC_CNT_TOP = 8'hff;

   typedef enum logic [2:0] {
      UTCC_M_TIMER8 = 3'h0,
      UTCC_M_DIV8 = 3'h1,
      UTCC_M_PWM8 = 3'h2,
      UTCC_M_RSVD = 3'h3,
      UTCC_M_TIMER16 = 3'h4,
      UTCC_M_WARMUP = 3'h5,
      UTCC_M_PWM16 = 3'h6,
      UTCC_M_PULSE16 = 3'h7
   } utcc_mode_e;

   typedef enum logic [2:0] {
      UTCC_CK_SLOWEST = 3'h0,
      UTCC_CK_FC_DIV7 = 3'h1,
      UTCC_CK_FC_DIV5 = 3'h2,
      UTCC_CK_FC_DIV3 = 3'h3,
      UTCC_CK_FS = 3'h4,
      UTCC_CK_FC_DIV1 = 3'h5,
      UTCC_CK_FC = 3'h6,
      UTCC_CK_PIN = 3'h7
   } utcc_clk_e;

endpackage

// ---- verification/test_upper_timer_counter_control.sv ----
// self-checking bench for the upper timer/counter control block
`timescale 1ns/1ps
`default_nettype none
module test_upper_timer_counter_control;
   import utcc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic fs_clk_in = 1'b0;
   logic counter_pin_in = 1'b0;
   logic [2:0] lower_clock_select = 3'h0;
   logic [2:0] lower_mode_select = 3'h0;
   logic lower_overflow = 1'b0;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic lower_source_tick;
   wire logic timer_out;
   wire logic irq;
   int failures = 0;
   int n_checks = 0;
   logic [31:0] rd;
   logic seen;

   always #5 hclk = ~hclk;
   int fs_cnt = 0;

   // slow clock of 74 hclk periods, driven on the rising edge like every input
   always @(posedge hclk) begin
      fs_cnt <= (fs_cnt == 36) ? 0 : fs_cnt + 1;
      if (fs_cnt == 36) fs_clk_in <= ~fs_clk_in;
   end

   utcc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .fs_clk_in(fs_clk_in), .counter_pin_in(counter_pin_in),
      .lower_clock_select(lower_clock_select), .lower_mode_select(lower_mode_select),
      .lower_overflow(lower_overflow), .lower_source_tick(lower_source_tick),
      .timer_out(timer_out), .irq(irq));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                           output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      hsel <= 1'b0;
   endtask

   task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_xfer(1'b1, a, d, q);
   endtask

   task automatic bus_rd(input logic [31:0] a, output logic [31:0] q);
      bus_xfer(1'b0, a, 32'h0, q);
   endtask

   task automatic wait_irq(input int n, output logic hit);
      hit = 1'b0;
      repeat (n) begin
         @(posedge hclk);
         if (irq === 1'b1) hit = 1'b1;
      end
   endtask

   task automatic t_reset_regs();
      logic [31:0] a [6] = '{UTCC_CTRL_ADDR, UTCC_PERIOD_ADDR, UTCC_PWIDTH_ADDR, UTCC_CFG_ADDR,
                             UTCC_STATUS_ADDR, UTCC_ENABLE_ADDR};
      logic [31:0] e [6] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 6; i++) begin
         bus_rd(a[i], rd);
         chk("reset value", e[i], rd);
      end
      bus_wr(UTCC_PWIDTH_ADDR, 32'h5a);
      bus_rd(UTCC_PWIDTH_ADDR, rd);
      chk("pulse width", 32'h5a, rd);
      bus_wr(32'h0000_0088, 32'ha5);
      bus_rd(32'h0000_0088, rd);
      chk("unmapped read", 32'h0, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      $display("test reset_regs done");
   endtask

   task automatic t_timer_irq();
      bus_wr(UTCC_ENABLE_ADDR, 32'h1);
      bus_wr(UTCC_PERIOD_ADDR, 32'h4);
      bus_wr(UTCC_CTRL_ADDR, 32'h68);
      wait_irq(40, seen);
      chk("timer irq", 32'h1, {31'h0, seen});
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("match status", 32'h1, rd);
      // stop write keeps clock and mode unchanged
      bus_wr(UTCC_CTRL_ADDR, 32'h60);
      bus_wr(UTCC_CLEAR_ADDR, 32'h1);
      // irq trails status by a cycle, so let the cleared level reach it
      tick(2);
      wait_irq(30, seen);
      chk("irq after stop", 32'h0, {31'h0, seen});
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("status after stop", 32'h0, rd);
      bus_wr(UTCC_ENABLE_ADDR, 32'h0);
      bus_wr(UTCC_CTRL_ADDR, 32'h68);
      wait_irq(30, seen);
      chk("masked irq", 32'h0, {31'h0, seen});
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("masked status", 32'h1, rd);
      bus_wr(UTCC_CTRL_ADDR, 32'h60);
      bus_wr(UTCC_CLEAR_ADDR, 32'h3);
      $display("test timer_irq done");
   endtask

   task automatic count_out(input int n, output int edges);
      logic prev;
      edges = 0;
      prev = timer_out;
      repeat (n) begin
         @(posedge hclk);
         if (timer_out !== prev) edges++;
         prev = timer_out;
      end
   endtask

   task automatic t_divider();
      int edges;
      bus_wr(UTCC_PERIOD_ADDR, 32'h2);
      bus_wr(UTCC_CTRL_ADDR, 32'h69);
      count_out(30, edges);
      chk("divider toggles", 32'h1, {31'h0, edges >= 4});
      bus_wr(UTCC_CTRL_ADDR, 32'h61);
      bus_wr(UTCC_CFG_ADDR, 32'h1 << UTCC_CFG_ODIS_BIT);
      bus_wr(UTCC_CTRL_ADDR, 32'h69);
      count_out(30, edges);
      chk("disabled output", 32'h0, {31'h0, timer_out});
      chk("disabled edges", 32'h0, edges);
      bus_wr(UTCC_CTRL_ADDR, 32'h61);
      bus_wr(UTCC_CFG_ADDR, 32'h0);
      $display("test divider done");
   endtask

   task automatic t_reserved();
      int edges;
      bus_wr(UTCC_CLEAR_ADDR, 32'h3);
      bus_wr(UTCC_ENABLE_ADDR, 32'h3);
      bus_wr(UTCC_CTRL_ADDR, 32'h6b);
      count_out(40, edges);
      chk("reserved edges", 32'h0, edges);
      chk("reserved irq", 32'h0, {31'h0, irq});
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("reserved status", 32'h0, rd);
      bus_wr(UTCC_CTRL_ADDR, 32'h63);
      $display("test reserved done");
   endtask

   task automatic t_ff_modes();
      logic exp;
      lower_mode_select <= UTCC_LOWER_CASCADE;
      for (int m = 0; m < 8; m++) begin
         // run stays low, so the flip-flop just follows its control bit
         bus_wr(UTCC_CTRL_ADDR, 32'he0 | m);
         tick(4);
         exp = (m == 1) || (m == 2) || (m == 6) || (m == 7);
         chk("ff output by mode", {31'h0, exp}, {31'h0, timer_out});
         bus_wr(UTCC_CTRL_ADDR, 32'h60 | m);
         tick(4);
         chk("ff cleared", 32'h0, {31'h0, timer_out});
      end
      $display("test ff_modes done");
   endtask

   task automatic t_cascade();
      logic [2:0] ms [3] = '{3'h4, 3'h5, 3'h7};
      bus_wr(UTCC_PERIOD_ADDR, 32'h2);
      // the sixteen-bit timer, warm-up and pulse modes step the upper byte only on lower overflow
      for (int k = 0; k < 3; k++) begin
         bus_wr(UTCC_CLEAR_ADDR, 32'h3);
         bus_wr(UTCC_CTRL_ADDR, 32'h68 | ms[k]);
         tick(30);
         bus_rd(UTCC_STATUS_ADDR, rd);
         chk("no overflow no count", 32'h0, rd);
         repeat (3) begin
            @(posedge hclk);
            lower_overflow <= 1'b1;
            @(posedge hclk);
            lower_overflow <= 1'b0;
            tick(3);
         end
         tick(4);
         bus_rd(UTCC_STATUS_ADDR, rd);
         chk("cascade match", 32'h1, rd);
         bus_wr(UTCC_CTRL_ADDR, 32'h60 | ms[k]);
      end
      bus_wr(UTCC_CLEAR_ADDR, 32'h3);
      lower_mode_select <= 3'h0;
      $display("test cascade done");
   endtask

   task automatic t_event_pin();
      bus_wr(UTCC_PERIOD_ADDR, 32'h1);
      bus_wr(UTCC_CTRL_ADDR, 32'h78);
      tick(20);
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("pin idle status", 32'h0, rd);
      repeat (3) begin
         @(posedge hclk);
         counter_pin_in <= 1'b1;
         tick(5);
         counter_pin_in <= 1'b0;
         tick(5);
      end
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("pin match status", 32'h1, rd);
      bus_wr(UTCC_CTRL_ADDR, 32'h70);
      bus_wr(UTCC_CLEAR_ADDR, 32'h3);
      $display("test event_pin done");
   endtask

   task automatic t_pwm_clocks();
      int edges;
      bus_wr(UTCC_CLEAR_ADDR, 32'h3);
      bus_wr(UTCC_PERIOD_ADDR, 32'h1);
      // fc taps /2^7, /2^5, /2^3 each give two ticks well inside 300 cycles
      for (int c = 1; c < 4; c++) begin
         bus_wr(UTCC_CTRL_ADDR, (c << 4) | 32'h8);
         tick(300);
         bus_rd(UTCC_STATUS_ADDR, rd);
         chk("fc tap match", 32'h1, rd);
         bus_wr(UTCC_CTRL_ADDR, c << 4);
         bus_wr(UTCC_CLEAR_ADDR, 32'h3);
      end
      bus_wr(UTCC_CFG_ADDR, 32'h1 << UTCC_CFG_SLOW_BIT);
      bus_wr(UTCC_CTRL_ADDR, 32'h38);
      tick(100);
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("fc tap in low clock", 32'h0, rd);
      bus_wr(UTCC_CTRL_ADDR, 32'h30);
      bus_wr(UTCC_CTRL_ADDR, 32'h48);
      tick(200);
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("fs in low clock", 32'h1, rd);
      bus_wr(UTCC_CTRL_ADDR, 32'h40);
      bus_wr(UTCC_CLEAR_ADDR, 32'h3);
      bus_wr(UTCC_CFG_ADDR, 32'h0);
      // one wrap period holds one width pulse: rise at 0x80, fall at the wrap
      bus_wr(UTCC_PWIDTH_ADDR, 32'h80);
      bus_wr(UTCC_CTRL_ADDR, 32'h5a);
      count_out(600, edges);
      chk("pwm8 edges", 32'h2, edges);
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("pwm8 wrap status", 32'h2, rd);
      bus_wr(UTCC_CTRL_ADDR, 32'h52);
      bus_wr(UTCC_CLEAR_ADDR, 32'h3);
      lower_mode_select <= UTCC_LOWER_CASCADE;
      lower_overflow <= 1'b1;
      bus_wr(UTCC_CTRL_ADDR, 32'h6e);
      count_out(300, edges);
      chk("pwm16 edges", 32'h2, edges);
      bus_rd(UTCC_STATUS_ADDR, rd);
      chk("pwm16 wrap status", 32'h2, rd);
      bus_wr(UTCC_CTRL_ADDR, 32'h66);
      lower_overflow <= 1'b0;
      lower_mode_select <= 3'h0;
      bus_wr(UTCC_CLEAR_ADDR, 32'h3);
      $display("test pwm_clocks done");
   endtask

   task automatic t_source_tick();
      lower_clock_select <= 3'h6;
      tick(4);
      chk("fc source tick", 32'h1, {31'h0, lower_source_tick});
      lower_clock_select <= 3'h7;
      tick(6);
      chk("quiet pin tick", 32'h0, {31'h0, lower_source_tick});
      $display("test source_tick done");
   endtask

   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_regs();
      t_timer_irq();
      t_divider();
      t_reserved();
      t_ff_modes();
      t_cascade();
      t_event_pin();
      t_pwm_clocks();
      t_source_tick();
      conclude();
   end

   // the tests take a few thousand cycles; this is ample
   initial begin
      #200000;
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
